// ===== bench/qdc_host.sv
// host model: issues register requests one strobe cycle at a time
`timescale 1ns/1ps
module qdc_host (
   input wire logic i_clk, // register clock
   output qdc_pkg::qdc_req_t o_req, // request into the register bank
   input wire logic [15:0] i_rdata, // read data
   input wire logic i_rvalid // read data valid
);
   import qdc_pkg::*;
   initial o_req = '0;
   // one transfer; an idle edge first keeps strobes from being set twice in one step
   task automatic xfer(input bit wr, input bit pm, input logic [7:0] page,
         input logic [7:0] addr, input logic [15:0] d, output logic [16:0] r);
      @(posedge i_clk);
      #1;
      o_req = '{wr: wr, rd: !wr, pmbus: pm, page: page, addr: addr, wdata: d};
      @(posedge i_clk);
      #1;
      r = {i_rvalid, i_rdata};
      // released fields show the inverse so stale values cannot pass
      o_req = '{wr: 1'b0, rd: 1'b0, pmbus: !pm, page: ~page, addr: ~addr, wdata: ~d};
   endtask : xfer
endmodule : qdc_host

// ===== bench/tb.sv
// testbench: model-checked host traffic into the quad dac common registers
`timescale 1ns/1ps
module tb;
   import qdc_pkg::*;
   logic i_clk = 1'b0;
   logic i_reset = 1'b1;
   qdc_req_t req;
   logic [15:0] rdata;
   logic rvalid;
   qdc_cfg_t cfg;
   logic [15:0] code [QDC_NCH];
   qdc_trig_t trig;
   logic locked;
   int n_errors = 0;
   int tests_run = 0;
   int seed = 96;
   logic [15:0] m_cfg = 16'h0FFF;
   logic [15:0] m_code [QDC_NCH] = '{default: 16'h0000};
   bit armed = 1'b0;
   logic [16:0] r;
   logic [15:0] w;
   // clock generator, 5 ns period
   always #2.5 i_clk = ~i_clk;
   qdc_regs #(.TEN_BIT(1'b0)) i_dut (.i_clk(i_clk), .i_reset(i_reset), .i_req(req),
      .o_rdata(rdata), .o_rvalid(rvalid), .o_cfg(cfg), .o_code(code), .o_trig(trig),
      .o_locked(locked));
   qdc_host i_host (.i_clk(i_clk), .o_req(req), .i_rdata(rdata), .i_rvalid(rvalid));
   // compare a read answer, a channel code or the lock and config state
   task automatic check(input logic [16:0] got, input logic [16:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD %0t value %h expected %h", $time, got, exp);
      end
   endtask : check
   // compare the trigger pulses
   task automatic check_trig(input qdc_trig_t exp);
      tests_run++;
      if (trig !== exp) begin
         n_errors++;
         $display("BAD %0t pulses %h expected %h", $time, trig, exp);
      end
   endtask : check_trig
   // access register k (0-3 channel, 4 config, 5 trigger) and update the model
   task automatic access(input bit wr, input bit pm, input int k, input logic [15:0] d);
      logic [7:0] pg;
      logic [7:0] ad;
      pg = (k < 4) ? 8'(k) : QDC_PAGE_COMMON;
      if (pm) ad = (k < 4) ? QDC_PMB_DATA : (k == 4) ? QDC_PMB_CFG : QDC_PMB_TRG;
      else ad = (k < 4) ? QDC_ADDR_CH0 + 8'(k) : (k == 4) ? QDC_ADDR_CFG : QDC_ADDR_TRG;
      i_host.xfer(wr, pm, pg, ad, d, r);
      if (wr && k < 4 && !m_cfg[14]) m_code[k] = d & 16'hFFF0;
      if (wr && k == 4) begin
         if (!m_cfg[14] || (armed && !d[14])) m_cfg = d;
         armed = 1'b0;
      end
      if (wr && k == 5) armed = (d[15:12] == 4'h5);
   endtask : access
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : conclude
   // watchdog against a hung handshake
   initial begin
      #20000;
      n_errors++;
      conclude();
   end
   // main sequence
   initial begin
      repeat (20) @(posedge i_clk);
      #1 i_reset = 1'b0;
      check({locked, cfg}, {1'b0, 16'h0FFF});
      access(0, 0, 4, 16'h0000);
      check(r, {1'b1, 16'h0FFF});
      access(0, 1, 5, 16'h0000);
      check(r, 17'h10000);
      // random codes, configs and trigger pulses over both addressing modes
      for (int i = 0; i < 8; i++) begin
         w = 16'($random(seed));
         access(1, i[0], i % 4, w);
         access(0, !i[0], i % 4, 16'h0000);
         check(r, {1'b1, m_code[i % 4]});
         check({1'b0, code[i % 4]}, {1'b0, m_code[i % 4]});
         w[14] = 1'b0;
         access(1, i[0], 4, w);
         check({locked, cfg}, {1'b0, m_cfg});
         access(0, !i[0], 4, 16'h0000);
         check(r, {1'b1, m_cfg});
         access(1, i[0], 5, w & 16'h00DF);
         check_trig({w[7:6], w[4:0], 1'b0});
      end
      // lock, then refused writes and wrong unlock attempts
      access(1, 0, 4, 16'h4000);
      check({locked, cfg}, {1'b1, 16'h4000});
      access(1, 1, 2, 16'hABCD);
      access(0, 0, 2, 16'h0000);
      check(r, {1'b1, m_code[2]});
      access(1, 0, 5, 16'h0080);
      check_trig('0);
      access(1, 0, 4, 16'h0000);
      check({locked, cfg}, {1'b1, 16'h4000});
      access(1, 0, 5, 16'h6000);
      access(1, 0, 4, 16'h0000);
      check({locked, cfg}, {1'b1, 16'h4000});
      access(1, 0, 5, 16'h5000);
      access(0, 0, 5, 16'h0000);
      check(r, {1'b1, 16'h5000});
      access(1, 1, 4, 16'h0123);
      check({locked, cfg}, {1'b0, m_cfg});
      // soft reset through the reset field
      access(1, 0, 5, 16'h0A00);
      check_trig(8'h01);
      @(posedge i_clk);
      #1;
      m_cfg = 16'h0FFF;
      m_code = '{default: 16'h0000};
      check({locked, cfg}, {1'b0, 16'h0FFF});
      access(0, 0, 3, 16'h0000);
      check(r, 17'h10000);
      // unmapped index reads zero
      i_host.xfer(1'b0, 1'b0, 8'h00, 8'h30, 16'h0000, r);
      check(r, 17'h10000);
      conclude();
   end
endmodule : tb

// ===== hw/qdc_pkg.sv
// package: register map, field layout and types of the quad dac common config registers
package qdc_pkg;
   // register indices on the direct port
   localparam logic [7:0] QDC_ADDR_CH0 = 8'h19;
   localparam logic [7:0] QDC_ADDR_CH3 = 8'h1C;
   localparam logic [7:0] QDC_ADDR_CFG = 8'h1F;
   localparam logic [7:0] QDC_ADDR_TRG = 8'h20;
   // pmbus page and command codes
   localparam logic [7:0] QDC_PAGE_COMMON = 8'hFF;
   localparam logic [7:0] QDC_PAGE_CH3 = 8'h03;
   localparam logic [7:0] QDC_PMB_CFG = 8'hE3;
   localparam logic [7:0] QDC_PMB_TRG = 8'hE4;
   localparam logic [7:0] QDC_PMB_DATA = 8'h21;
   // reset values
   localparam logic [15:0] QDC_CFG_RESET = 16'h0FFF;
   localparam logic [15:0] QDC_TRG_RESET = 16'h0000;
   localparam logic [15:0] QDC_CODE_RESET = 16'h0000;
   // masks of stored code bits: 12-bit and 10-bit variants
   localparam logic [15:0] QDC_CODE_MASK_12 = 16'hFFF0;
   localparam logic [15:0] QDC_CODE_MASK_10 = 16'hFFC0;
   // trigger register fields
   localparam int QDC_TRG_UNLOCK_HI = 15;
   localparam int QDC_TRG_UNLOCK_LO = 12;
   localparam int QDC_TRG_RESET_HI = 11;
   localparam int QDC_TRG_RESET_LO = 8;
   localparam int QDC_TRG_LOAD = 7;
   localparam int QDC_TRG_CLEAR = 6;
   localparam int QDC_TRG_FDUMP = 4;
   localparam int QDC_TRG_PROTECT = 3;
   localparam int QDC_TRG_READ1 = 2;
   localparam int QDC_TRG_NVPROG = 1;
   localparam int QDC_TRG_NVLOAD = 0;
   localparam logic [3:0] QDC_UNLOCK_CODE = 4'h5;
   localparam logic [3:0] QDC_POR_CODE = 4'hA;
   localparam int QDC_CFG_LOCK = 14;
   localparam int QDC_CFG_FDSEL = 13;
   localparam int QDC_NCH = 4;

   // voltage power-down selections
   typedef enum logic [1:0] {
      QDC_VPD_UP = 2'h0,
      QDC_VPD_10K = 2'h1,
      QDC_VPD_100K = 2'h2,
      QDC_VPD_HIZ = 2'h3
   } qdc_vpd_t;

   // per-channel power-down controls, three bits each
   typedef struct packed {
      qdc_vpd_t voltage_powerdown_mode;
      logic current_powerdown;
   } qdc_chpd_t;

   // common configuration register as laid out, bit 15 first
   typedef struct packed {
      logic comparator_latch_select;
      logic register_lock;
      logic fault_dump_read_select;
      logic internal_ref_enable;
      qdc_chpd_t [QDC_NCH-1:0] pd;
   } qdc_cfg_t;

   // register request from the serial front end
   typedef struct packed {
      logic wr;
      logic rd;
      logic pmbus;
      logic [7:0] page;
      logic [7:0] addr;
      logic [15:0] wdata;
   } qdc_req_t;

   // one-cycle trigger pulses
   typedef struct packed {
      logic load_outputs_trigger;
      logic clear_outputs_trigger;
      logic fault_dump;
      logic protect;
      logic single_read_trigger;
      logic nonvolatile_program_trigger;
      logic nonvolatile_reload_trigger;
      logic por;
   } qdc_trig_t;
endpackage : qdc_pkg

// ===== hw/qdc_regs.sv
// module: common configuration, trigger and channel code registers of the quad dac
`timescale 1ns/1ps

// Summary of operation
// - channel code is unsigned binary, msb-first
// - low four bits ignored, ten-bit drops two more
// - lock bit set blocks code, config and trigger action writes; the unlock field stays writable
// - bit 13 picks fault-dump address 00/01
// - two-bit voltage power-down mode per channel
// - one-bit current power-down per channel
// - configuration resets to 0FFF, all powered down
// - trigger resets zero with documented field layout
// - pmbus page FF reaches E3 and E4
// - only unlock code 0101 is accepted
// - reset code 1010 fires self-clearing por
module qdc_regs #(
   parameter bit TEN_BIT = 1'b0 // 1 selects the ten-bit variant
) (
   input wire logic i_clk, // 200 mhz clock
   input wire logic i_reset, // synchronous reset, active high
   input wire qdc_pkg::qdc_req_t i_req, // decoded register request
   output logic [15:0] o_rdata, // read data
   output logic o_rvalid, // read data valid pulse
   output qdc_pkg::qdc_cfg_t o_cfg, // common configuration fields
   output logic [15:0] o_code [qdc_pkg::QDC_NCH], // channel codes, left aligned
   output qdc_pkg::qdc_trig_t o_trig, // trigger pulses
   output logic o_locked // register lock state
);
   import qdc_pkg::*;

   qdc_cfg_t cfg;
   logic [3:0] unlock_field;
   logic unlock_armed;
   logic por_pending;
   logic soft_reset;
   logic sel_cfg;
   logic sel_trg;
   logic sel_ch;
   logic [1:0] ch_idx;
   logic cfg_wr_ok;
   logic trg_wr;
   logic [15:0] code_mask;
   logic [15:0] next_rdata;
   logic [15:0] code [QDC_NCH];

   assign soft_reset = i_reset | por_pending;
   assign code_mask = TEN_BIT ? QDC_CODE_MASK_10 : QDC_CODE_MASK_12;

   // address decode for the direct index and the pmbus page/command form
   always_comb begin
      sel_cfg = 1'b0;
      sel_trg = 1'b0;
      sel_ch = 1'b0;
      ch_idx = 2'h0;
      if (i_req.pmbus) begin
         sel_cfg = (i_req.page == QDC_PAGE_COMMON) && (i_req.addr == QDC_PMB_CFG);
         sel_trg = (i_req.page == QDC_PAGE_COMMON) && (i_req.addr == QDC_PMB_TRG);
         sel_ch = (i_req.page <= QDC_PAGE_CH3) && (i_req.addr == QDC_PMB_DATA);
         ch_idx = i_req.page[1:0];
      end else begin
         sel_cfg = i_req.addr == QDC_ADDR_CFG;
         sel_trg = i_req.addr == QDC_ADDR_TRG;
         sel_ch = (i_req.addr >= QDC_ADDR_CH0) && (i_req.addr <= QDC_ADDR_CH3);
         ch_idx = 2'(i_req.addr - QDC_ADDR_CH0);
      end
   end

   // a locked config write only passes when armed and clearing the lock
   assign cfg_wr_ok = i_req.wr && sel_cfg && (!cfg.register_lock || (unlock_armed &&
      !i_req.wdata[QDC_CFG_LOCK]));
   assign trg_wr = i_req.wr && sel_trg;

   // common configuration register
   always_ff @(posedge i_clk) begin
      if (soft_reset) begin
         cfg <= qdc_cfg_t'(QDC_CFG_RESET);
      end else if (cfg_wr_ok) begin
         cfg <= qdc_cfg_t'(i_req.wdata);
      end
   end

   // unlock field and arming: only the unlock code arms, any config write disarms
   always_ff @(posedge i_clk) begin
      if (soft_reset) begin
         unlock_field <= QDC_TRG_RESET[QDC_TRG_UNLOCK_HI:QDC_TRG_UNLOCK_LO];
         unlock_armed <= 1'b0;
      end else if (trg_wr) begin
         unlock_field <= i_req.wdata[QDC_TRG_UNLOCK_HI:QDC_TRG_UNLOCK_LO];
         unlock_armed <= i_req.wdata[QDC_TRG_UNLOCK_HI:QDC_TRG_UNLOCK_LO] ==
            QDC_UNLOCK_CODE;
      end else if (i_req.wr && sel_cfg) begin
         unlock_armed <= 1'b0;
      end
   end

   // trigger pulses; all actions self-clear after one cycle
   always_ff @(posedge i_clk) begin
      if (soft_reset) begin
         o_trig <= '0;
         por_pending <= 1'b0;
      end else begin
         o_trig <= '0;
         por_pending <= 1'b0;
         if (trg_wr && !cfg.register_lock) begin
            o_trig.load_outputs_trigger <= i_req.wdata[QDC_TRG_LOAD];
            o_trig.clear_outputs_trigger <= i_req.wdata[QDC_TRG_CLEAR];
            o_trig.fault_dump <= i_req.wdata[QDC_TRG_FDUMP];
            o_trig.protect <= i_req.wdata[QDC_TRG_PROTECT];
            o_trig.single_read_trigger <= i_req.wdata[QDC_TRG_READ1];
            o_trig.nonvolatile_program_trigger <= i_req.wdata[QDC_TRG_NVPROG];
            o_trig.nonvolatile_reload_trigger <= i_req.wdata[QDC_TRG_NVLOAD];
            if (i_req.wdata[QDC_TRG_RESET_HI:QDC_TRG_RESET_LO] == QDC_POR_CODE) begin
               o_trig.por <= 1'b1;
               por_pending <= 1'b1;
            end
         end
      end
   end

   // channel code registers, low bits forced to zero
   for (genvar ch = 0; ch < QDC_NCH; ch++) begin : g_ch
      always_ff @(posedge i_clk) begin
         if (soft_reset) begin
            code[ch] <= QDC_CODE_RESET;
         end else if (i_req.wr && sel_ch && ch_idx == 2'(ch) && !cfg.register_lock) begin
            code[ch] <= i_req.wdata & code_mask;
         end
      end
      assign o_code[ch] = code[ch];
   end

   // read mux; unmapped indices read zero, trigger actions read zero
   always_comb begin
      next_rdata = 16'h0000;
      if (sel_cfg) begin
         next_rdata = cfg;
      end else if (sel_trg) begin
         next_rdata = {unlock_field, 12'h000};
      end else if (sel_ch) begin
         next_rdata = code[ch_idx];
      end
   end

   // registered read answer, one cycle after the strobe
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         o_rdata <= 16'h0000;
         o_rvalid <= 1'b0;
      end else begin
         o_rvalid <= i_req.rd;
         o_rdata <= i_req.rd ? next_rdata : 16'h0000;
      end
   end

   assign o_cfg = cfg;
   assign o_locked = cfg.register_lock;

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_reset);

   // soft reset from the trigger reset field
   a_cfg_after_por: assert property (o_trig.por |=> o_cfg == QDC_CFG_RESET)
      else $error("config not reset after por trigger");
   a_por_self_clear: assert property (o_trig.por |=> !o_trig.por)
      else $error("por trigger did not self clear");
   a_por_from_code: assert property (
      trg_wr && !o_locked && !por_pending &&
      i_req.wdata[QDC_TRG_RESET_HI:QDC_TRG_RESET_LO] == QDC_POR_CODE |=> o_trig.por)
      else $error("reset code did not fire por");

   // lock and unlock sequence
   a_lock_holds_cfg: assert property (
      o_locked && !(unlock_armed && i_req.wr && sel_cfg && !i_req.wdata[QDC_CFG_LOCK]) &&
      !por_pending |=> $stable(o_cfg))
      else $error("locked configuration changed");
   a_unlock_seq: assert property (
      o_locked && unlock_armed && i_req.wr && sel_cfg && !i_req.wdata[QDC_CFG_LOCK] &&
      !por_pending |=> !o_locked)
      else $error("unlock sequence did not clear lock");
   a_cfg_disarms: assert property (
      i_req.wr && sel_cfg && !por_pending |=> !unlock_armed)
      else $error("config write left the unlock armed");
   a_arm_code_only: assert property (
      trg_wr && i_req.wdata[QDC_TRG_UNLOCK_HI:QDC_TRG_UNLOCK_LO] != QDC_UNLOCK_CODE &&
      !por_pending |=> !unlock_armed)
      else $error("non unlock code armed the unlock");
   a_arm_by_code: assert property (
      trg_wr && i_req.wdata[QDC_TRG_UNLOCK_HI:QDC_TRG_UNLOCK_LO] == QDC_UNLOCK_CODE &&
      !por_pending |=> unlock_armed)
      else $error("unlock code did not arm");
   a_locked_trig_quiet: assert property (o_locked && trg_wr |=> o_trig == '0)
      else $error("trigger fired while locked");
   a_locked_code_hold: assert property (
      o_locked && !por_pending |=> $stable(o_code[0]) && $stable(o_code[1]) &&
      $stable(o_code[2]) && $stable(o_code[3]))
      else $error("channel code changed while locked");

   // channel codes
   a_code_low_zero: assert property (
      (o_code[0] & ~code_mask) == 16'h0000 && (o_code[1] & ~code_mask) == 16'h0000 &&
      (o_code[2] & ~code_mask) == 16'h0000 && (o_code[3] & ~code_mask) == 16'h0000)
      else $error("ignored code bits not zero");
   a_code_write: assert property (
      i_req.wr && !i_req.pmbus && i_req.addr == QDC_ADDR_CH0 && !o_locked && !por_pending
      |=> o_code[0] == ($past(i_req.wdata) & code_mask))
      else $error("channel code not stored");

   // configuration fields after reset and after writes
   a_cfg_reset_val: assert property (
      $fell(i_reset) |-> o_cfg == QDC_CFG_RESET && !o_locked && o_code[0] == QDC_CODE_RESET)
      else $error("registers not at reset value");
   a_pd_reset_hiz: assert property (
      $fell(i_reset) |-> o_cfg.pd[0].voltage_powerdown_mode == QDC_VPD_HIZ &&
      o_cfg.pd[3].voltage_powerdown_mode == QDC_VPD_HIZ && o_cfg.pd[0].current_powerdown &&
      o_cfg.pd[3].current_powerdown)
      else $error("outputs not powered down after reset");
   a_cfg_write_val: assert property (
      cfg_wr_ok && !por_pending |=> o_cfg == $past(i_req.wdata))
      else $error("configuration write not stored");
   a_fault_sel_field: assert property (
      cfg_wr_ok && !por_pending |=>
      o_cfg.fault_dump_read_select == $past(i_req.wdata[QDC_CFG_FDSEL]))
      else $error("fault dump select not stored");

   // read answers
   a_pmbus_cfg_read: assert property (
      i_req.rd && i_req.pmbus && i_req.page == QDC_PAGE_COMMON && i_req.addr == QDC_PMB_CFG
      |=> o_rvalid && o_rdata == $past(o_cfg))
      else $error("pmbus config read mismatch");
   a_trg_read_layout: assert property (
      i_req.rd && sel_trg |=> o_rvalid && o_rdata[QDC_TRG_RESET_HI:0] == 12'h000)
      else $error("trigger actions read back nonzero");

   // trigger actions are single pulses
   a_load_pulse: assert property (
      trg_wr && !o_locked && !por_pending && i_req.wdata[QDC_TRG_LOAD]
      |=> o_trig.load_outputs_trigger ##1 !o_trig.load_outputs_trigger)
      else $error("load trigger not a single pulse");
   a_clear_pulse: assert property (
      trg_wr && !o_locked && !por_pending && i_req.wdata[QDC_TRG_CLEAR]
      |=> o_trig.clear_outputs_trigger ##1 !o_trig.clear_outputs_trigger)
      else $error("clear trigger not a single pulse");
endmodule : qdc_regs
